// File: verilog/ccop_timer.sv
// 16-bit capture/compare timer for one-shot pulses and pulse width measurement
// Overview of operation
// (R1) 16-bit up-counter free-runs on prescaler ticks
// (R2) rising input edge copies counter to capture0
// (R3) capture0 raises capture0 interrupt
// (R4) software loads compares with capture plus delay/width
// (R5) toggle bits 11 invert output on compares
// (R6) software clears toggle enables after pulse
// (R7) mask register suppresses each interrupt separately
// (R8) output may invert on capture0 event
// (R9) no-delay: compare1 match inverts, software disables
// (R10) falling edge copies counter to capture1
// (R11) capture1 raises capture1 interrupt
// (R12) software computes high width from captures
// (R13) software extends measurement beyond counter range
// (R14) software computes low width across periods
// (R15) run bit starts and stops the counter
// (R16) counter wraps from all ones to zero
module ccop_timer import ccop_pkg::*; #(
	parameter int PSC_DIV_W = 7
) (
	// clock and reset
	input  wire logic    pclk,
	input  wire logic    presetn,
	// register bus
	input  ccop_apb_req_t apb_req,
	output ccop_apb_rsp_t apb_rsp,
	// external pins
	input  wire logic    timer_ext_input,
	output logic         timer_pulse_output,
	// interrupt requests
	output ccop_irq_t    irq
);

	typedef struct packed {
		logic                  run_bit;
		logic                  toggle_on_compare0;
		logic                  toggle_on_compare1;
		logic                  toggle_on_capture0;
		logic [CCOP_PSC_W-1:0] psc_sel;
		logic [3:0]            mask;
		logic [CCOP_CNT_W-1:0] up_counter;
		logic [CCOP_CNT_W-1:0] capture_reg_0;
		logic [CCOP_CNT_W-1:0] capture_reg_1;
		logic [CCOP_CNT_W-1:0] compare_reg_0;
		logic [CCOP_CNT_W-1:0] compare_reg_1;
		logic                  output_flipflop;
		logic                  ext_s1;
		logic                  ext_s2;
		logic                  ext_prev;
		ccop_irq_t             irq;
		ccop_apb_rsp_t         rsp;
	} ccop_state_t;

	localparam ccop_state_t CCOP_RST = '{
		run_bit: 1'b0, toggle_on_compare0: 1'b0, toggle_on_compare1: 1'b0,
		toggle_on_capture0: 1'b0, psc_sel: CCOP_PSC_RST, mask: CCOP_MASK_RST,
		up_counter: CCOP_CNT_RST, capture_reg_0: CCOP_CNT_RST, capture_reg_1: CCOP_CNT_RST,
		compare_reg_0: CCOP_CNT_RST, compare_reg_1: CCOP_CNT_RST, output_flipflop: 1'b0,
		ext_s1: 1'b0, ext_s2: 1'b0, ext_prev: 1'b0, irq: '0, rsp: '0};

	ccop_state_t s_q;
	ccop_state_t s_d;

	logic                  tick;
	logic                  count_ev;
	logic [CCOP_CNT_W-1:0] cnt_inc;
	logic                  rise;
	logic                  fall;
	logic                  match0;
	logic                  match1;
	logic                  cap_tog;
	logic                  wr_ev;
	logic                  setup;

	function automatic logic [31:0] ccop_zext(input logic [CCOP_CNT_W-1:0] v);
		ccop_zext = {{(32 - CCOP_CNT_W){1'b0}}, v};
	endfunction

	function automatic logic ccop_mapped(input logic [CCOP_ADDR_W-1:0] a);
		ccop_mapped = (a <= CCOP_OFF_CMP1) && (a[1:0] == 2'h0);
	endfunction

	ccop_prescaler #(
		.DIV_W (PSC_DIV_W)
	) u_psc (
		.pclk    (pclk),
		.presetn (presetn),
		.run     (s_q.run_bit),
		.sel     (s_q.psc_sel),
		.tick    (tick)
	);

	// synchronised edges of the external input
	assign rise     = s_q.ext_s2 && !s_q.ext_prev;
	assign fall     = !s_q.ext_s2 && s_q.ext_prev;
	assign count_ev = s_q.run_bit && tick;                                  // (R15)
	assign cnt_inc  = s_q.up_counter + 1'b1;                                // (R16)
	// a match is the tick that brings the counter onto the compare value
	assign match0   = count_ev && (cnt_inc == s_q.compare_reg_0);
	assign match1   = count_ev && (cnt_inc == s_q.compare_reg_1);
	assign cap_tog  = rise && s_q.toggle_on_capture0;
	assign setup    = apb_req.psel && !apb_req.penable;
	assign wr_ev    = apb_req.psel && apb_req.penable && s_q.rsp.pready && apb_req.pwrite
	                  && !s_q.rsp.pslverr;

	always_comb begin
		s_d          = s_q;
		s_d.ext_s1   = timer_ext_input;
		s_d.ext_s2   = s_q.ext_s1;
		s_d.ext_prev = s_q.ext_s2;

		if (count_ev) begin
			s_d.up_counter = cnt_inc;                                       // (R1)
		end
		if (rise) begin
			s_d.capture_reg_0 = s_q.up_counter;                             // (R2)
		end
		if (fall) begin
			s_d.capture_reg_1 = s_q.up_counter;                             // (R10)
		end

		// simultaneous causes each invert once
		s_d.output_flipflop = s_q.output_flipflop
		                      ^ (match0 && s_q.toggle_on_compare0)          // (R5)
		                      ^ (match1 && s_q.toggle_on_compare1)          // (R9)
		                      ^ cap_tog;                                    // (R8)

		s_d.irq.capture0_irq       = rise && !s_q.mask[CCOP_IM_CAP0];       // (R3)
		s_d.irq.capture1_irq       = fall && !s_q.mask[CCOP_IM_CAP1];       // (R11)
		s_d.irq.compare0_match_irq = match0 && !s_q.mask[CCOP_IM_CMP0];     // (R7)
		s_d.irq.compare1_match_irq = match1 && !s_q.mask[CCOP_IM_CMP1];     // (R7)

		// no wait state: read data is sampled in setup, ready in the first access cycle
		s_d.rsp.pready = setup;
		if (setup) begin
			s_d.rsp.pslverr = !ccop_mapped(apb_req.paddr);
			s_d.rsp.prdata  = '0;
			case (apb_req.paddr)
				CCOP_OFF_RUN: begin
					s_d.rsp.prdata[0] = s_q.run_bit;
				end
				CCOP_OFF_FFCTL: begin
					s_d.rsp.prdata[CCOP_FF_TOG0]   = s_q.toggle_on_compare0;
					s_d.rsp.prdata[CCOP_FF_TOG1]   = s_q.toggle_on_compare1;
					s_d.rsp.prdata[CCOP_FF_TOGCAP] = s_q.toggle_on_capture0;
					s_d.rsp.prdata[CCOP_FF_STATE]  = s_q.output_flipflop;
				end
				CCOP_OFF_MODE:  s_d.rsp.prdata[CCOP_PSC_W-1:0] = s_q.psc_sel;
				CCOP_OFF_MASK:  s_d.rsp.prdata[3:0] = s_q.mask;
				CCOP_OFF_COUNT: s_d.rsp.prdata = ccop_zext(s_q.up_counter);
				CCOP_OFF_CAP0:  s_d.rsp.prdata = ccop_zext(s_q.capture_reg_0);
				CCOP_OFF_CAP1:  s_d.rsp.prdata = ccop_zext(s_q.capture_reg_1);
				CCOP_OFF_CMP0:  s_d.rsp.prdata = ccop_zext(s_q.compare_reg_0);
				CCOP_OFF_CMP1:  s_d.rsp.prdata = ccop_zext(s_q.compare_reg_1);
				default:        s_d.rsp.prdata = '0;
			endcase
		end

		if (wr_ev) begin
			case (apb_req.paddr)
				CCOP_OFF_RUN: begin
					s_d.run_bit = apb_req.pwdata[0];                        // (R15)
				end
				CCOP_OFF_FFCTL: begin
					s_d.toggle_on_compare0 = apb_req.pwdata[CCOP_FF_TOG0];
					s_d.toggle_on_compare1 = apb_req.pwdata[CCOP_FF_TOG1];
					s_d.toggle_on_capture0 = apb_req.pwdata[CCOP_FF_TOGCAP];
					// software clear overrides a toggle in the same cycle
					if (apb_req.pwdata[CCOP_FF_CLEAR]) begin
						s_d.output_flipflop = 1'b0;
					end
				end
				CCOP_OFF_MODE:  s_d.psc_sel = apb_req.pwdata[CCOP_PSC_W-1:0];
				CCOP_OFF_MASK:  s_d.mask = apb_req.pwdata[3:0];
				CCOP_OFF_CMP0:  s_d.compare_reg_0 = apb_req.pwdata[CCOP_CNT_W-1:0];
				CCOP_OFF_CMP1:  s_d.compare_reg_1 = apb_req.pwdata[CCOP_CNT_W-1:0];
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= CCOP_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign apb_rsp            = s_q.rsp;
	assign irq                = s_q.irq;
	assign timer_pulse_output = s_q.output_flipflop;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_rise_seen;
		rise;
	endsequence

	sequence s_fall_seen;
		fall;
	endsequence

	sequence s_rd_access;
		setup ##1 (apb_req.psel && apb_req.penable);
	endsequence

	property p_count_inc;
		count_ev |=> (s_q.up_counter == $past(s_q.up_counter) + 16'h0001);
	endproperty
	a_count_inc: assert property (p_count_inc) else $error("counter did not advance on tick"); // (R1)

	property p_cap0_take;
		s_rise_seen |=> (s_q.capture_reg_0 == $past(s_q.up_counter));
	endproperty
	a_cap0_take: assert property (p_cap0_take) else $error("capture0 missed the counter value"); // (R2)

	property p_cap0_irq;
		s_rise_seen ##0 !s_q.mask[CCOP_IM_CAP0] |=> irq.capture0_irq ##1 !irq.capture0_irq;
	endproperty
	a_cap0_irq: assert property (p_cap0_irq) else $error("capture0 interrupt not pulsed"); // (R3)

	property p_cmp_toggle;
		match0 && s_q.toggle_on_compare0 && !(match1 && s_q.toggle_on_compare1) && !cap_tog
		&& !wr_ev |=> (timer_pulse_output != $past(timer_pulse_output));
	endproperty
	a_cmp_toggle: assert property (p_cmp_toggle) else $error("compare0 match did not invert output"); // (R5)

	property p_mask_cmp1;
		s_q.mask[CCOP_IM_CMP1] |=> !irq.compare1_match_irq;
	endproperty
	a_mask_cmp1: assert property (p_mask_cmp1) else $error("masked compare1 interrupt raised"); // (R7)

	property p_cap_toggle;
		cap_tog && !match0 && !match1 && !wr_ev |=> (timer_pulse_output != $past(timer_pulse_output));
	endproperty
	a_cap_toggle: assert property (p_cap_toggle) else $error("capture did not invert output"); // (R8)

	property p_cmp1_only;
		match1 && !s_q.toggle_on_compare1 && !match0 && !cap_tog && !wr_ev
		|=> (timer_pulse_output == $past(timer_pulse_output));
	endproperty
	a_cmp1_only: assert property (p_cmp1_only) else $error("output inverted with toggle disabled"); // (R9)

	property p_cap1_take;
		s_fall_seen |=> (s_q.capture_reg_1 == $past(s_q.up_counter))
		&& (irq.capture1_irq == !$past(s_q.mask[CCOP_IM_CAP1]));
	endproperty
	a_cap1_take: assert property (p_cap1_take) else $error("capture1 or its interrupt wrong"); // (R10)

	property p_stop_hold;
		!s_q.run_bit [*2] |-> $stable(s_q.up_counter);
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("counter moved while stopped"); // (R15)

	property p_wrap;
		count_ev && (s_q.up_counter == 16'hFFFF) |=> (s_q.up_counter == 16'h0000);
	endproperty
	a_wrap: assert property (p_wrap) else $error("counter did not wrap to zero"); // (R16)

	property p_apb_ready;
		s_rd_access |-> apb_rsp.pready ##1 !apb_rsp.pready;
	endproperty
	a_apb_ready: assert property (p_apb_ready) else $error("apb ready not one cycle in access");

endmodule

// File: include/ccop_pkg.sv
// shared constants, register map and carrier types of the capture/compare one-shot timer
package ccop_pkg;

	localparam int CCOP_CNT_W  = 16;
	localparam int CCOP_ADDR_W = 8;
	localparam int CCOP_PSC_W  = 3;

	// register byte offsets
	localparam logic [CCOP_ADDR_W-1:0] CCOP_OFF_RUN   = 8'h00;
	localparam logic [CCOP_ADDR_W-1:0] CCOP_OFF_FFCTL = 8'h04;
	localparam logic [CCOP_ADDR_W-1:0] CCOP_OFF_MODE  = 8'h08;
	localparam logic [CCOP_ADDR_W-1:0] CCOP_OFF_MASK  = 8'h0C;
	localparam logic [CCOP_ADDR_W-1:0] CCOP_OFF_COUNT = 8'h10;
	localparam logic [CCOP_ADDR_W-1:0] CCOP_OFF_CAP0  = 8'h14;
	localparam logic [CCOP_ADDR_W-1:0] CCOP_OFF_CAP1  = 8'h18;
	localparam logic [CCOP_ADDR_W-1:0] CCOP_OFF_CMP0  = 8'h1C;
	localparam logic [CCOP_ADDR_W-1:0] CCOP_OFF_CMP1  = 8'h20;

	// flipflop_control fields
	localparam int CCOP_FF_TOG0   = 0;
	localparam int CCOP_FF_TOG1   = 1;
	localparam int CCOP_FF_TOGCAP = 2;
	localparam int CCOP_FF_CLEAR  = 3;
	localparam int CCOP_FF_STATE  = 4;

	// timer_irq_mask fields, 1 suppresses
	localparam int CCOP_IM_CAP0 = 0;
	localparam int CCOP_IM_CAP1 = 1;
	localparam int CCOP_IM_CMP0 = 2;
	localparam int CCOP_IM_CMP1 = 3;

	// reset values
	localparam logic [CCOP_CNT_W-1:0] CCOP_CNT_RST  = 16'h0000;
	localparam logic [3:0]            CCOP_MASK_RST = 4'hF;
	localparam logic [CCOP_PSC_W-1:0] CCOP_PSC_RST  = 3'h0;

	typedef struct packed {
		logic                   psel;
		logic                   penable;
		logic                   pwrite;
		logic [CCOP_ADDR_W-1:0] paddr;
		logic [31:0]            pwdata;
	} ccop_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} ccop_apb_rsp_t;

	typedef struct packed {
		logic capture0_irq;
		logic capture1_irq;
		logic compare0_match_irq;
		logic compare1_match_irq;
	} ccop_irq_t;

endpackage

// File: verilog/ccop_prescaler.sv
// prescaler producing the one-cycle counting tick for the up-counter
module ccop_prescaler import ccop_pkg::*; #(
	parameter int DIV_W = 7
) (
	// clock and reset
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// control
	input  wire logic                  run,
	input  wire logic [CCOP_PSC_W-1:0] sel,
	// tick out
	output logic                       tick
);

	typedef struct packed {
		logic [DIV_W-1:0] cnt;
		logic             tick;
	} ccop_psc_state_t;

	ccop_psc_state_t s_q;
	ccop_psc_state_t s_d;
	logic [DIV_W-1:0] div_mask;

	always_comb begin
		s_d      = s_q;
		div_mask = DIV_W'((1 << sel) - 1);
		// restart on stop so the first tick after start is a full period
		s_d.cnt  = s_q.cnt + 1'b1;
		s_d.tick = run && ((s_q.cnt & div_mask) == div_mask);
		if (!run) begin
			s_d.cnt = '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick = s_q.tick;

endmodule

// File: verif/ccop_pulse_src.sv
// partner model: external pulse source and load on the pulse output
module ccop_pulse_src (
	// clock
	input  wire logic pclk,
	// pins
	output logic      timer_ext_input,
	input  wire logic timer_pulse_output
);
	timeunit 1ns;
	timeprecision 1ns;
	int hi_cnt = 0;
	int last_hi = 0;
	initial begin
		timer_ext_input = 1'b0;
	end
	// load side: length of each high phase in pclk cycles
	always @(posedge pclk) begin
		if (timer_pulse_output === 1'b1) begin
			hi_cnt <= hi_cnt + 1;
		end else begin
			if (hi_cnt != 0) last_hi <= hi_cnt;
			hi_cnt <= 0;
		end
	end
	// input held low between pulses, pulses well above the synchroniser limit
	task automatic drive_pulse(input int hi_cyc, input int lo_cyc);
		@(posedge pclk);
		timer_ext_input <= 1'b1;
		repeat (hi_cyc) @(posedge pclk);
		timer_ext_input <= 1'b0;
		repeat (lo_cyc) @(posedge pclk);
	endtask
endmodule

// File: verif/ccop_timer_test.sv
// self-checking testbench of the capture/compare one-shot timer
module ccop_timer_test import ccop_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [15:0] DLY = 16'h003C;
	localparam logic [15:0] WID = 16'h0014;
	localparam logic [15:0] WND = 16'h0028;
	logic          pclk = 1'b0;
	logic          presetn = 1'b0;
	ccop_apb_req_t req = '0;
	ccop_apb_rsp_t rsp;
	logic          ext_in;
	logic          pulse_out;
	ccop_irq_t     irq;
	int            mismatches = 0;
	int            cmp_count = 0;
	int            n_c0 = 0;
	int            n_c1 = 0;
	int            n_m0 = 0;
	int            n_m1 = 0;
	logic [31:0]   a;
	logic [31:0]   b;
	logic          e;

	always #25 pclk = ~pclk;

	ccop_timer #(.PSC_DIV_W(3)) u_ccop_timer (
		.pclk               (pclk),
		.presetn            (presetn),
		.apb_req            (req),
		.apb_rsp            (rsp),
		.timer_ext_input    (ext_in),
		.timer_pulse_output (pulse_out),
		.irq                (irq)
	);
	ccop_pulse_src u_ccop_pulse_src (
		.pclk               (pclk),
		.timer_ext_input    (ext_in),
		.timer_pulse_output (pulse_out)
	);

	always @(posedge pclk) begin
		if (irq.capture0_irq === 1'b1) n_c0 <= n_c0 + 1;
		if (irq.capture1_irq === 1'b1) n_c1 <= n_c1 + 1;
		if (irq.compare0_match_irq === 1'b1) n_m0 <= n_m0 + 1;
		if (irq.compare1_match_irq === 1'b1) n_m1 <= n_m1 + 1;
	end

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// one transfer, then an idle cycle so psel is never set twice in a step
	task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] wd,
			output logic [31:0] rdat, output logic err);
		int n;
		n = 0;
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= w;
		req.paddr <= ad;
		req.pwdata <= wd;
		@(posedge pclk);
		req.penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			mismatches++;
			report_and_stop();
		end
		rdat = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		logic [31:0] x;
		logic        y;
		xfer(1'b1, ad, d, x, y);
	endtask

	task automatic rd(input logic [7:0] ad, output logic [31:0] d);
		logic y;
		xfer(1'b0, ad, 32'h0, d, y);
	endtask

	task automatic wait_out(input logic lvl);
		int n;
		n = 0;
		while (pulse_out !== lvl && n < 500) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 500) begin
			mismatches++;
			report_and_stop();
		end
	endtask

	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(CCOP_OFF_MASK, a);
		chk("mask reset", 32'h0000000F, a);
		rd(CCOP_OFF_RUN, a);
		chk("run reset", 32'h0, a);
		xfer(1'b0, 8'h24, 32'h0, a, e);
		chk("unmapped error", 32'h1, {31'h0, e});
		wr(CCOP_OFF_RUN, 32'h1);
		rd(CCOP_OFF_COUNT, a);
		rd(CCOP_OFF_COUNT, b);
		chk("count step", 32'h3, b - a);
		// slower prescaler tap: any four cycles hold exactly one tick
		wr(CCOP_OFF_MODE, 32'h2);
		rd(CCOP_OFF_MODE, a);
		chk("mode readback", 32'h2, a);
		rd(CCOP_OFF_COUNT, a);
		@(posedge pclk);
		rd(CCOP_OFF_COUNT, b);
		chk("count step div4", 32'h1, b - a);
		wr(CCOP_OFF_MODE, 32'h0);
		wr(CCOP_OFF_RUN, 32'h0);
		rd(CCOP_OFF_COUNT, a);
		rd(CCOP_OFF_COUNT, b);
		chk("count held", a, b);
		wr(CCOP_OFF_RUN, 32'h1);
		// one-shot with delay
		wr(CCOP_OFF_MASK, 32'hE);
		u_ccop_pulse_src.drive_pulse(10, 2);
		rd(CCOP_OFF_CAP0, a);
		wr(CCOP_OFF_CMP0, {16'h0, a[15:0] + DLY});
		wr(CCOP_OFF_CMP1, {16'h0, a[15:0] + DLY + WID});
		wr(CCOP_OFF_FFCTL, 32'h3);
		wr(CCOP_OFF_MASK, 32'h7);
		wait_out(1'b1);
		wait_out(1'b0);
		@(posedge pclk);
		chk("delayed width", {16'h0, WID}, u_ccop_pulse_src.last_hi);
		wr(CCOP_OFF_FFCTL, 32'h0);
		chk("irq counts a", 32'h01000001, {n_c0[7:0], n_c1[7:0], n_m0[7:0], n_m1[7:0]});
		// pulse longer than the count range, toggles off, all interrupts suppressed
		wr(CCOP_OFF_MASK, 32'hF);
		rd(CCOP_OFF_COUNT, a);
		u_ccop_pulse_src.drive_pulse(65552, 12);
		rd(CCOP_OFF_COUNT, b);
		// 65568 ticks between the two reads
		chk("count wrap", {16'h0, a[15:0] + 16'h0020}, b);
		rd(CCOP_OFF_CAP0, a);
		rd(CCOP_OFF_CAP1, b);
		// software adds the one full range that it timed itself
		chk("long width", 32'd65552, 32'h00010000 + {16'h0, b[15:0] - a[15:0]});
		chk("output idle", 32'h0, {31'h0, pulse_out});
		chk("irq counts b", 32'h01000001, {n_c0[7:0], n_c1[7:0], n_m0[7:0], n_m1[7:0]});
		// one-shot without delay
		wr(CCOP_OFF_FFCTL, 32'h8);
		wr(CCOP_OFF_FFCTL, 32'h6);
		wr(CCOP_OFF_MASK, 32'h6);
		u_ccop_pulse_src.drive_pulse(10, 2);
		chk("capture toggle", 32'h1, {31'h0, pulse_out});
		rd(CCOP_OFF_FFCTL, a);
		chk("ffctl state", 32'h16, a);
		rd(CCOP_OFF_CAP0, a);
		wr(CCOP_OFF_CMP1, {16'h0, a[15:0] + WND});
		wait_out(1'b0);
		@(posedge pclk);
		b = u_ccop_pulse_src.last_hi;
		chk("no-delay width", 32'h1, {31'h0, b >= WND - 1 && b <= WND + 1});
		wr(CCOP_OFF_FFCTL, 32'h0);
		// high and low width measurement
		wr(CCOP_OFF_MASK, 32'hC);
		u_ccop_pulse_src.drive_pulse(25, 5);
		rd(CCOP_OFF_CAP0, a);
		rd(CCOP_OFF_CAP1, b);
		chk("high width", 32'd25, {16'h0, b[15:0] - a[15:0]});
		// low phase: 5 idle, two transfers and the launch edge make 12 cycles
		u_ccop_pulse_src.drive_pulse(25, 5);
		rd(CCOP_OFF_CAP0, a);
		chk("low width", 32'd12, {16'h0, a[15:0] - b[15:0]});
		chk("irq counts c", 32'h04020002, {n_c0[7:0], n_c1[7:0], n_m0[7:0], n_m1[7:0]});
		report_and_stop();
	end
endmodule
